// *** inc/link_alarm_defs.svh ***
// link_alarm_defs.svh: offsets, fields, reset values, timing counts
// assumes an 8-bit register port with 12-bit addresses
`ifndef LINK_ALARM_DEFS_SVH
`define LINK_ALARM_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_POWER_TRIM_A 12'h037
`define OFS_SOFT_CAL_TRIG 12'h06c
`define OFS_POWER_TRIM_B 12'h29a
`define OFS_POWER_TRIM_GLITCH 12'h29b
`define OFS_POWER_TRIM_D 12'h29c
`define OFS_LINK_CTRL 12'h200
`define OFS_ALARM_FLAGS 12'h2c0
`define OFS_ALARM_SUMMARY 12'h2c1
`define OFS_ALARM_MASK 12'h2c2
`define OFS_LANE_FIFO_FLAGS 12'h2c4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_POWER_TRIM_A 8'h4b
`define RST_POWER_TRIM_B 8'h0f
`define RST_POWER_TRIM_GLITCH 8'h04
`define RST_POWER_TRIM_D 8'h1b
`define RST_LINK_CTRL 8'h00
`define RST_ALARM_MASK 8'h00

// ----------------------------------------------------------------
// link control fields
// ----------------------------------------------------------------
`define CTRL_LINK_EN 0
`define CTRL_CHAN_A_PD 1
`define CTRL_CHAN_B_PD 2
`define CTRL_CAL_EN 3
`define CTRL_FOREGROUND 4
`define CTRL_TRIG_EN 5
`define CTRL_STAT_SEL 6
`define CTRL_ENC_64B66B 7

// ----------------------------------------------------------------
// alarm flag positions
// ----------------------------------------------------------------
`define ALM_CPLL 0
`define ALM_SPLL 1
`define ALM_NOT_DATA 2
`define ALM_SYSREF 3
`define ALM_CLK_UPSET 4
`define ALM_FIFO 5
`define ALM_CAUSES 6
`define NUM_LANES 8

// ----------------------------------------------------------------
// thresholds and timing
// ----------------------------------------------------------------
`define GLITCH_HP_LEVEL 8'h04
`define MF_PERIOD 8'd32
`define ILAS_MULTIFRAMES 3'd4
`define SAMPLE_CLK_MHZ 100
`define TRANS_DELAY_NS 6000
`define TRANS_DELAY_CYC \
   (`TRANS_DELAY_NS * `SAMPLE_CLK_MHZ / 1000)

`endif

// *** inc/link_alarm_pkg.sv ***
// link_alarm_pkg.sv: types shared by the link control logic
// assumes nothing of its surroundings
package link_alarm_pkg;

   // gray codes along idle -> cgs -> ilas -> data
   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_CGS = 2'b01,
      LINK_ILAS = 2'b11,
      LINK_DATA = 2'b10
   } link_state_t;

endpackage : link_alarm_pkg

// *** design/trigger_timer.sv ***
// trigger_timer.sv: fixed delay from a trigger to a one-cycle pulse
// assumes clk is the sample clock; retriggers while busy are ignored
`timescale 1ns/10ps
`include "link_alarm_defs.svh"

module trigger_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   output logic fire
);

   localparam logic [15:0] DELAY = 16'(`TRANS_DELAY_CYC);

   logic [15:0] cnt_q;
   logic busy_q;
   logic fire_q;
   wire logic last = busy_q && (cnt_q == 16'h0001);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
         busy_q <= 1'b0;
         fire_q <= 1'b0;
      end else begin
         fire_q <= last;
         if (start && !busy_q) begin
            cnt_q <= DELAY;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 16'h0001;
            busy_q <= !last;
         end
      end
   end

   assign fire = fire_q;

endmodule : trigger_timer

// *** design/link_alarm_ctrl.sv ***
// link_alarm_ctrl.sv: link enable, frame counter, alarms, power trims
// assumes a decoded 8-bit register port and inputs synchronous to clk
//
// Functional notes
// - link disabled: reset, serializers off, clocks gated
// - link enable one releases link block
// - sysref resets multiframe or extended multiblock counter
// - without sysref frame counter free-runs
// - sync request starts cgs then ilas unless 64b66b selected
// - six alarm causes detected
// - sticky alarm bits cleared by writing one
// - unmasked alarms reach summary register
// - status pin shows alarm when selected
// - channel clock mismatch sets clock upset flag
// - lane fifo pointer upset sets lane flag
// - link enable toggle resets lane fifos
// - glitch trim of four matches high performance
// - triggered core transition 500-1000 samples later
// - foreground calibration gives no core transitions
`timescale 1ns/10ps
`include "link_alarm_defs.svh"

module link_alarm_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic cpll_locked,
   input wire logic spll_locked,
   input wire logic sysref_captured,
   input wire logic sysref_realign,
   input wire logic sync_n,
   input wire logic chan_a_clk_phase,
   input wire logic chan_b_clk_phase,
   input wire logic [7:0] lane_fifo_err,
   input wire logic cal_trigger_pin,
   input wire logic cal_core_req,
   input wire logic cal_done,
   output logic link_rst_n,
   output logic serializer_pd,
   output logic link_clk_en,
   output logic lane_fifo_rst_n,
   output logic frame_ctr_rst,
   output logic frame_edge,
   output logic [1:0] link_state,
   output logic cal_status_pin,
   output logic core_transition,
   output logic glitch_matches_hp
);

   // ----------------------------------------------------------------
   // register write decode
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic [7:0] trim_a_q;
   logic [7:0] trim_b_q;
   logic [7:0] trim_glitch_q;
   logic [7:0] trim_d_q;
   logic [7:0] alarm_mask_q;
   logic [5:0] alarm_flags_q;
   logic [7:0] lane_flags_q;

   wire logic wr_ctrl = reg_wr && (reg_addr == `OFS_LINK_CTRL);
   wire logic wr_trim_a = reg_wr && (reg_addr == `OFS_POWER_TRIM_A);
   wire logic wr_trim_b = reg_wr && (reg_addr == `OFS_POWER_TRIM_B);
   wire logic wr_trim_g = reg_wr && (reg_addr == `OFS_POWER_TRIM_GLITCH);
   wire logic wr_trim_d = reg_wr && (reg_addr == `OFS_POWER_TRIM_D);
   wire logic wr_mask = reg_wr && (reg_addr == `OFS_ALARM_MASK);
   wire logic wr_flags = reg_wr && (reg_addr == `OFS_ALARM_FLAGS);
   wire logic wr_lanes = reg_wr && (reg_addr == `OFS_LANE_FIFO_FLAGS);
   wire logic wr_soft_trig = reg_wr && (reg_addr == `OFS_SOFT_CAL_TRIG);

   wire logic link_en = ctrl_q[`CTRL_LINK_EN];
   wire logic enc_64b = ctrl_q[`CTRL_ENC_64B66B];
   wire logic foreground = ctrl_q[`CTRL_FOREGROUND];
   wire logic trig_en = ctrl_q[`CTRL_TRIG_EN];
   wire logic stat_sel = ctrl_q[`CTRL_STAT_SEL];
   wire logic both_chans = !ctrl_q[`CTRL_CHAN_A_PD]
      && !ctrl_q[`CTRL_CHAN_B_PD];

   // trims are plain storage; they take any write so a careless
   // sequence is not silently dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `RST_LINK_CTRL;
         trim_a_q <= `RST_POWER_TRIM_A;
         trim_b_q <= `RST_POWER_TRIM_B;
         trim_glitch_q <= `RST_POWER_TRIM_GLITCH;
         trim_d_q <= `RST_POWER_TRIM_D;
         alarm_mask_q <= `RST_ALARM_MASK;
      end else begin
         if (wr_ctrl) ctrl_q <= reg_wdata;
         if (wr_trim_a) trim_a_q <= reg_wdata;
         if (wr_trim_b) trim_b_q <= reg_wdata;
         if (wr_trim_g) trim_glitch_q <= reg_wdata;
         if (wr_trim_d) trim_d_q <= reg_wdata;
         if (wr_mask) alarm_mask_q <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // link enable gating
   // ----------------------------------------------------------------
   logic link_rst_n_q;
   logic ser_pd_q;
   logic clk_en_q;
   logic fifo_rst_n_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link_rst_n_q <= 1'b0;
         ser_pd_q <= 1'b1;
         clk_en_q <= 1'b0;
         fifo_rst_n_q <= 1'b0;
      end else begin
         link_rst_n_q <= link_en;
         ser_pd_q <= !link_en;
         clk_en_q <= link_en;
         fifo_rst_n_q <= link_en;
      end
   end

   // ----------------------------------------------------------------
   // frame counter
   // ----------------------------------------------------------------
   logic [7:0] mf_cnt_q;
   logic mf_rst_q;
   logic mf_edge_q;
   wire logic mf_wrap = (mf_cnt_q == `MF_PERIOD - 8'd1);

   // free-running from reset gives arbitrary phase with no sysref
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mf_cnt_q <= 8'h00;
         mf_rst_q <= 1'b0;
         mf_edge_q <= 1'b0;
      end else begin
         mf_rst_q <= sysref_captured;
         if (sysref_captured || mf_wrap) begin
            mf_cnt_q <= 8'h00;
         end else begin
            mf_cnt_q <= mf_cnt_q + 8'h01;
         end
         mf_edge_q <= sysref_captured || mf_wrap;
      end
   end

   // ----------------------------------------------------------------
   // link state
   // ----------------------------------------------------------------
   link_alarm_pkg::link_state_t state_q;
   link_alarm_pkg::link_state_t state_d;
   logic [2:0] ilas_cnt_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         link_alarm_pkg::LINK_IDLE: begin
            if (link_en) begin
               state_d = enc_64b ? link_alarm_pkg::LINK_DATA
                  : link_alarm_pkg::LINK_CGS;
            end
         end
         link_alarm_pkg::LINK_CGS: begin
            if (sync_n && mf_edge_q) begin
               state_d = link_alarm_pkg::LINK_ILAS;
            end
         end
         link_alarm_pkg::LINK_ILAS: begin
            if (!sync_n) begin
               state_d = link_alarm_pkg::LINK_CGS;
            end else if (mf_edge_q && ilas_cnt_q == `ILAS_MULTIFRAMES) begin
               state_d = link_alarm_pkg::LINK_DATA;
            end
         end
         link_alarm_pkg::LINK_DATA: begin
            if (!sync_n && !enc_64b) begin
               state_d = link_alarm_pkg::LINK_CGS;
            end
         end
         default: state_d = link_alarm_pkg::LINK_IDLE;
      endcase
      if (!link_en) begin
         state_d = link_alarm_pkg::LINK_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= link_alarm_pkg::LINK_IDLE;
         ilas_cnt_q <= 3'd0;
      end else begin
         state_q <= state_d;
         if (state_q != link_alarm_pkg::LINK_ILAS) begin
            ilas_cnt_q <= 3'd0;
         end else if (mf_edge_q) begin
            ilas_cnt_q <= ilas_cnt_q + 3'd1;
         end
      end
   end

   // ----------------------------------------------------------------
   // alarm detection
   // ----------------------------------------------------------------
   logic half_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) half_q <= 1'b0;
      else half_q <= !half_q;
   end

   // compare once per half-rate cycle; only meaningful with both on
   wire logic clk_upset = half_q && both_chans && link_en
      && (chan_a_clk_phase != chan_b_clk_phase);
   wire logic [7:0] lane_evt = link_en ? lane_fifo_err : 8'h00;

   wire logic [5:0] alarm_evt = {
      |lane_evt,
      clk_upset,
      sysref_realign,
      state_q != link_alarm_pkg::LINK_DATA,
      !spll_locked,
      !cpll_locked
   };

   // set wins over the write-one clear
   genvar gi;
   generate
      for (gi = 0; gi < `ALM_CAUSES; gi++) begin : g_alarm
         wire logic clr = wr_flags && reg_wdata[gi];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) alarm_flags_q[gi] <= 1'b0;
            else if (alarm_evt[gi]) alarm_flags_q[gi] <= 1'b1;
            else if (clr) alarm_flags_q[gi] <= 1'b0;
         end
      end
      for (gi = 0; gi < `NUM_LANES; gi++) begin : g_lane
         wire logic clr = wr_lanes && reg_wdata[gi];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) lane_flags_q[gi] <= 1'b0;
            else if (lane_evt[gi]) lane_flags_q[gi] <= 1'b1;
            else if (clr) lane_flags_q[gi] <= 1'b0;
         end
      end
   endgenerate

   wire logic summary = |(alarm_flags_q & ~alarm_mask_q[5:0]);

   // ----------------------------------------------------------------
   // calibration core transitions
   // ----------------------------------------------------------------
   logic trig_pin_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) trig_pin_q <= 1'b0;
      else trig_pin_q <= cal_trigger_pin;
   end

   wire logic trig_evt = (cal_trigger_pin && !trig_pin_q) || wr_soft_trig;
   wire logic bg_cal = ctrl_q[`CTRL_CAL_EN] && !foreground;
   logic timer_fire;

   trigger_timer u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .start(trig_evt && trig_en && bg_cal),
      .fire(timer_fire)
   );

   wire logic core_evt = bg_cal
      && (trig_en ? timer_fire : cal_core_req);

   // ----------------------------------------------------------------
   // outputs and read port
   // ----------------------------------------------------------------
   logic stat_q;
   logic core_q;
   logic glitch_q;
   logic [7:0] rdata_q;
   logic [7:0] rd_mux;

   always_comb begin
      case (reg_addr)
         `OFS_LINK_CTRL: rd_mux = ctrl_q;
         `OFS_POWER_TRIM_A: rd_mux = trim_a_q;
         `OFS_POWER_TRIM_B: rd_mux = trim_b_q;
         `OFS_POWER_TRIM_GLITCH: rd_mux = trim_glitch_q;
         `OFS_POWER_TRIM_D: rd_mux = trim_d_q;
         `OFS_ALARM_MASK: rd_mux = alarm_mask_q;
         `OFS_ALARM_FLAGS: rd_mux = {2'b00, alarm_flags_q};
         `OFS_ALARM_SUMMARY: rd_mux = {7'h00, summary};
         `OFS_LANE_FIFO_FLAGS: rd_mux = lane_flags_q;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= 1'b0;
         core_q <= 1'b0;
         glitch_q <= 1'b1;
         rdata_q <= 8'h00;
      end else begin
         stat_q <= stat_sel ? summary : cal_done;
         core_q <= core_evt;
         glitch_q <= (trim_glitch_q >= `GLITCH_HP_LEVEL);
         if (reg_rd) rdata_q <= rd_mux;
      end
   end

   assign reg_rdata = rdata_q;
   assign link_rst_n = link_rst_n_q;
   assign serializer_pd = ser_pd_q;
   assign link_clk_en = clk_en_q;
   assign lane_fifo_rst_n = fifo_rst_n_q;
   assign frame_ctr_rst = mf_rst_q;
   assign frame_edge = mf_edge_q;
   assign link_state = state_q;
   assign cal_status_pin = stat_q;
   assign core_transition = core_q;
   assign glitch_matches_hp = glitch_q;

endmodule : link_alarm_ctrl

// *** dv/link_rx_model.sv ***
// link_rx_model.sv: receiver end of the serial link, drives sync_n
// assumes link_state and frame_edge of link_alarm_ctrl, bench resync
`timescale 1ns/10ps
module link_rx_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] link_state,
   input wire logic frame_edge,
   input wire logic resync,
   output logic sync_n,
   output logic buf_release
);
   // release point one cycle after the frame edge (registered); only once
   // every lane is in data, so delay may run past one frame period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_release <= 1'b0;
      end else begin
         buf_release <= frame_edge
            && link_state == 2'b10;
      end
   end
   // request held while idle so a fresh link starts with cgs unless 64b66b is selected
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_n <= 1'b0;
      end else if (resync || link_state == 2'b00) begin
         sync_n <= 1'b0;
      end else if (link_state == 2'b01) begin
         sync_n <= 1'b1;
      end
   end
endmodule : link_rx_model

// *** dv/link_alarm_ctrl_properties.sv ***
// link_alarm_ctrl_properties.sv: port checks of link_alarm_ctrl
// assumes one clk domain and active-low asynchronous rst_n
`timescale 1ns/10ps
module link_alarm_ctrl_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic sysref_captured,
   input wire logic sync_n,
   input wire logic cal_trigger_pin,
   input wire logic link_rst_n,
   input wire logic serializer_pd,
   input wire logic link_clk_en,
   input wire logic lane_fifo_rst_n,
   input wire logic frame_ctr_rst,
   input wire logic frame_edge,
   input wire logic [1:0] link_state,
   input wire logic core_transition,
   input wire logic glitch_matches_hp
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ------------------------------
   // shadow of written control
   // ------------------------------
   logic [7:0] ctrl_q;
   logic [7:0] glitch_q;
   logic pin_q;
   logic [10:0] wait_q;
   logic tmode;
   logic trig_ev;
   assign tmode = ctrl_q[3] && !ctrl_q[4] && ctrl_q[5];
   assign trig_ev = tmode && ((reg_wr && reg_addr == 12'h06c)
      || (cal_trigger_pin && !pin_q));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= 8'h00;
         glitch_q <= 8'h04;
         pin_q <= 1'b0;
         wait_q <= 11'h000;
      end else begin
         pin_q <= cal_trigger_pin;
         if (reg_wr && reg_addr == 12'h200) ctrl_q <= reg_wdata;
         if (reg_wr && reg_addr == 12'h29b) glitch_q <= reg_wdata;
         // stops at 1100 so a lost transition stays visible
         if (core_transition) wait_q <= 11'h000;
         else if (wait_q != 11'h000 && wait_q < 11'h44c)
            wait_q <= wait_q + 11'h001;
         else if (trig_ev && wait_q == 11'h000) wait_q <= 11'h001;
      end
   end
   // ------------------------------
   // assertions
   // ------------------------------
   AST_GATE_OFF: assert property (!link_rst_n |-> serializer_pd
      && !link_clk_en && !lane_fifo_rst_n) else $error("link gating broken");
   AST_ENABLE: assert property (
      reg_wr && reg_addr == 12'h200 && reg_wdata[0]
      |-> ##2 link_rst_n && link_clk_en && !serializer_pd)
      else $error("no start");
   AST_DISABLE: assert property (
      reg_wr && reg_addr == 12'h200 && !reg_wdata[0]
      |-> ##2 !link_rst_n && !lane_fifo_rst_n)
      else $error("no link reset");
   AST_IDLE: assert property (!link_rst_n && !$past(link_rst_n)
      |-> link_state == 2'b00) else $error("state runs while disabled");
   AST_SYSREF: assert property (
      sysref_captured |-> ##[1:2] frame_ctr_rst)
      else $error("sysref did not reset frame counter");
   AST_FREERUN: assert property (
      frame_edge |=> ##[0:31] frame_edge)
      else $error("frame counter not free running");
   AST_RESYNC: assert property (
      $fell(sync_n) && link_rst_n && !ctrl_q[7]
      |-> ##[1:2] link_state == 2'b01) else $error("sync request ignored");
   AST_GLITCH: assert property (reg_wr && reg_addr == 12'h29b
      |-> ##2 glitch_matches_hp == (glitch_q >= 8'h04))
      else $error("glitch level");
   AST_FG: assert property (
      ctrl_q[4] && $past(ctrl_q[4]) |-> !core_transition)
      else $error("core transition in foreground mode");
   AST_TRIG: assert property (trig_ev && wait_q == 11'h000
      |-> ##[500:1000] core_transition) else $error("transition late");
   AST_TRIG_EARLY: assert property (core_transition && tmode
      |-> wait_q >= 11'h1f4) else $error("transition early");
endmodule : link_alarm_ctrl_properties

bind link_alarm_ctrl link_alarm_ctrl_properties
   u_link_alarm_ctrl_properties (.*);

// *** dv/adc_link_enable_alarm_ctrl_bench.sv ***
// adc_link_enable_alarm_ctrl_bench.sv: self-checking bench
// assumes link_alarm_ctrl, link_rx_model and the bound checker
`timescale 1ns/10ps
module adc_link_enable_alarm_ctrl_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cpll_locked = 1'b1;
   logic spll_locked = 1'b1;
   logic sysref_captured = 1'b0;
   logic sysref_realign = 1'b0;
   logic chan_a_clk_phase = 1'b0;
   logic chan_b_clk_phase = 1'b0;
   logic [7:0] lane_fifo_err = 8'h00;
   logic cal_trigger_pin = 1'b0;
   logic cal_core_req = 1'b0;
   logic cal_done = 1'b0;
   logic resync = 1'b0;
   logic sync_n, link_rst_n, serializer_pd, link_clk_en, lane_fifo_rst_n;
   logic frame_ctr_rst, frame_edge, cal_status_pin, core_transition;
   logic glitch_matches_hp;
   logic buf_release;
   logic [1:0] link_state;
   logic [7:0] reg_rdata;
   logic [11:0] trim_adr [4] = '{12'h037, 12'h29a, 12'h29b, 12'h29c};
   logic [7:0] hp_val [4] = '{8'h4b, 8'h0f, 8'h04, 8'h1b};
   logic [7:0] lp_val [4] = '{8'h46, 8'h06, 8'h00, 8'h14};
   int error_cnt = 0;
   int num_checks = 0;
   int n;
   link_alarm_ctrl u_link_alarm_ctrl (.*);
   link_rx_model u_link_rx_model (.*);
   always #5 clk = ~clk;
   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic chk(input string what, input logic [7:0] got,
      input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk("reg_rdata", reg_rdata, exp);
   endtask : rd
   task automatic wait_state(input logic [1:0] s, input int lim);
      n = 0;
      while (link_state !== s && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk("link_state", 8'(link_state), 8'(s));
   endtask : wait_state
   task automatic wait_ct(input int lim);
      n = 0;
      while (core_transition !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_ct
   task automatic gating(input logic on);
      repeat (2) @(negedge clk);
      chk("gating", {link_rst_n, serializer_pd, link_clk_en, lane_fifo_rst_n},
         on ? 8'h0b : 8'h04);
   endtask : gating
   task automatic cause(input int i);
      @(negedge clk);
      case (i)
         0: cpll_locked = 1'b0;
         1: spll_locked = 1'b0;
         2: resync = 1'b1;
         3: sysref_realign = 1'b1;
         4: chan_a_clk_phase = 1'b1;
         default: lane_fifo_err = 8'h04;
      endcase
      repeat (4) @(negedge clk);
      {cpll_locked, spll_locked, resync, sysref_realign} = 4'b1100;
      chan_a_clk_phase = 1'b0;
      lane_fifo_err = 8'h00;
      if (i == 2) wait_state(2'b10, 300);
   endtask : cause
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_trims();
      gating(1'b0);
      for (int i = 0; i < 4; i++) begin
         rd(trim_adr[i], hp_val[i]);
         wr(trim_adr[i], lp_val[i]);
         rd(trim_adr[i], lp_val[i]);
      end
      @(negedge clk);
      chk("glitch_matches_hp", 8'(glitch_matches_hp), 8'h00);
      wr(12'h29b, 8'h04);
      @(negedge clk);
      chk("glitch_matches_hp", 8'(glitch_matches_hp), 8'h01);
      for (int i = 0; i < 4; i++) wr(trim_adr[i], hp_val[i]);
      wr(12'h3ff, 8'h5a);
      rd(12'h3ff, 8'h00);
      rd(12'h06c, 8'h00);
   endtask : t_trims
   task automatic t_link();
      wr(12'h200, 8'h01);
      gating(1'b1);
      wait_state(2'b10, 300);
      n = 0;
      while (buf_release !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("buf_release", 8'(n < 40), 8'h01);
      resync = 1'b1;
      wait_state(2'b01, 4);
      resync = 1'b0;
      wait_state(2'b10, 300);
      wr(12'h200, 8'h00);
      gating(1'b0);
      wait_state(2'b00, 2);
      // 64b66b start skips cgs and ilas entirely
      wr(12'h200, 8'h81);
      wait_state(2'b10, 3);
      wr(12'h200, 8'h00);
      wr(12'h200, 8'h01);
      wait_state(2'b10, 300);
   endtask : t_link
   task automatic t_alarms();
      wr(12'h2c2, 8'hff);
      wr(12'h2c0, 8'hff);
      for (int i = 0; i < 6; i++) begin
         cause(i);
         if (i == 5) begin
            rd(12'h2c4, 8'h04);
            wr(12'h2c4, 8'h04);
            rd(12'h2c4, 8'h00);
         end
         rd(12'h2c0, 8'h01 << i);
         wr(12'h2c0, 8'h00);
         rd(12'h2c0, 8'h01 << i);
         wr(12'h2c0, 8'h01 << i);
         rd(12'h2c0, 8'h00);
      end
      wr(12'h2c2, 8'hfe);
      wr(12'h200, 8'h41);
      cause(0);
      rd(12'h2c1, 8'h01);
      chk("cal_status_pin", 8'(cal_status_pin), 8'h01);
      wr(12'h2c0, 8'h01);
      wr(12'h2c2, 8'hff);
      cause(0);
      rd(12'h2c1, 8'h00);
      chk("cal_status_pin", 8'(cal_status_pin), 8'h00);
      wr(12'h200, 8'h01);
      cal_done = 1'b1;
      repeat (2) @(negedge clk);
      chk("cal_status_pin", 8'(cal_status_pin), 8'h01);
   endtask : t_alarms
   task automatic t_frame();
      @(negedge clk);
      sysref_captured = 1'b1;
      @(negedge clk);
      sysref_captured = 1'b0;
      chk("frame_ctr_rst", 8'(frame_ctr_rst), 8'h01);
      n = 0;
      while (frame_edge !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      chk("sysref frame_edge", 8'(n < 4), 8'h01);
      @(negedge clk);
      n = 1;
      while (frame_edge !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("frame period", 8'(n), 8'h20);
   endtask : t_frame
   task automatic t_trigger();
      wr(12'h200, 8'h29);
      wr(12'h06c, 8'h00);
      wait_ct(1100);
      chk("soft trigger delay", 8'(n >= 500 && n <= 1000), 8'h01);
      @(negedge clk);
      cal_trigger_pin = 1'b1;
      wait_ct(1100);
      cal_trigger_pin = 1'b0;
      chk("pin trigger delay", 8'(n >= 500 && n <= 1000), 8'h01);
      wr(12'h200, 8'h09);
      @(negedge clk);
      cal_core_req = 1'b1;
      @(negedge clk);
      cal_core_req = 1'b0;
      wait_ct(3);
      chk("untriggered transition", 8'(n < 3), 8'h01);
      wr(12'h200, 8'h39);
      wr(12'h06c, 8'h00);
      wait_ct(1100);
      chk("foreground transition", 8'(n == 1100), 8'h01);
   endtask : t_trigger
   // ------------------------------
   // run control
   // ------------------------------
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_trims();
      t_link();
      t_alarms();
      t_frame();
      t_trigger();
      final_report();
   end
   // whole run needs roughly 3400 cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      final_report();
   end
endmodule : adc_link_enable_alarm_ctrl_bench
